// ===== logic/rrm_consts.svh
// Offsets, field positions, reset values and rates of the register map
`ifndef RRM_CONSTS_SVH
`define RRM_CONSTS_SVH

`define RRM_OFS_CTL1 5'h00
`define RRM_OFS_TIME_FIRST 5'h03
`define RRM_OFS_TIME_LAST 5'h09
`define RRM_OFS_EXT_LAST 5'h0c
`define RRM_OFS_DAY_ALM 5'h0d
`define RRM_OFS_WDAY_ALM 5'h0e
`define RRM_OFS_SQW_CTL 5'h0f
`define RRM_OFS_WD_CTL 5'h10
`define RRM_OFS_WD_VAL 5'h11
`define RRM_OFS_TS_CTL 5'h12
`define RRM_OFS_CAP_SEC 5'h13
`define RRM_OFS_CAP_MIN 5'h14
`define RRM_OFS_CAP_HOUR 5'h15
`define RRM_OFS_CAP_DAY 5'h16
`define RRM_OFS_CAP_MON 5'h17
`define RRM_OFS_CAP_YEAR 5'h18
`define RRM_OFS_AGING 5'h19
`define RRM_OFS_RAM_HI 5'h1a
`define RRM_OFS_RAM_LO 5'h1b
`define RRM_OFS_RAM_WR 5'h1c
`define RRM_OFS_RAM_RD 5'h1d
`define RRM_OFS_WRAP 5'h1b
`define RRM_OFS_ZERO 5'h00

// Primary control bit positions
`define RRM_C1_EXTERNAL_CLOCK_CHECK_MODE 7
`define RRM_C1_UNUSED 6
`define RRM_C1_STOP 5
`define RRM_C1_TAMPER 4
`define RRM_C1_POWERUP_RESET_OVERRIDE_ENABLE 3
`define RRM_C1_HOUR12 2
`define RRM_C1_MIN_IE 1
`define RRM_C1_SEC_IE 0

// Implemented-bit masks
`define RRM_MSK_CTL1 8'hbf
`define RRM_MSK_DAY_ALM 8'hbf
`define RRM_MSK_WDAY_ALM 8'h87
`define RRM_MSK_SQW_CTL 8'hc7
`define RRM_MSK_WD_CTL 8'he3
`define RRM_MSK_TS_CTL 8'hdf
`define RRM_MSK_TS_CTL_KEEP 8'h1f
`define RRM_MSK_SEC 8'h7f
`define RRM_MSK_HOUR 8'h3f
`define RRM_MSK_MON 8'h1f
`define RRM_MSK_YEAR 8'hff
`define RRM_MSK_AGING 8'h0f
`define RRM_MSK_RAM_HI 8'h01

// Reset values of reset-bearing fields
`define RRM_RST_CTL1 8'h00
`define RRM_RST_ALM_EN 1'b1
`define RRM_RST_SQW_CTL 8'h00
`define RRM_RST_WD_CTL 8'h03
`define RRM_RST_TS_MODE 2'h0
`define RRM_RST_AGING 8'h08
`define RRM_RST_RAM_PTR 9'h000

// Alarm enable and timestamp-off positions
`define RRM_ALM_EN_BIT 7
`define RRM_TS_OFF_BIT 6

// Square-wave select codes
`define RRM_SQW_1HZ 3'h6
`define RRM_SQW_OFF 3'h7
`define RRM_SQW_FAST_MAX 3'h2
`define RRM_DIV_PRE_BITS 3
`define RRM_DIV_BITS 16
`define RRM_DIV_TOP 16'hffff

`endif

// ===== logic/rrm_pkg.sv
// Types shared by the register map and its bench
package rrm_pkg;

    typedef logic [7:0] rrm_byte_t;

    // Current time and date, one BCD byte each
    typedef struct packed {
        rrm_byte_t sec;
        rrm_byte_t min;
        rrm_byte_t hour;
        rrm_byte_t day;
        rrm_byte_t mon;
        rrm_byte_t year;
    } rrm_time_s;

    // Decoded primary control bits
    typedef struct packed {
        logic external_clock_check_mode;
        logic stop;
        logic tamper_flag;
        logic powerup_reset_override_enable_en;
        logic hour12;
        logic min_ie;
        logic sec_ie;
    } rrm_ctl1_s;

    // One register access from the serial front end
    typedef struct packed {
        logic load;
        logic [4:0] addr;
        logic access;
        logic write;
        rrm_byte_t wdata;
    } rrm_req_s;

endpackage : rrm_pkg

// ===== logic/rrm_ram.sv
// General purpose byte memory with registered read data
`timescale 1ns/1ps
module rrm_ram (
    input wire logic i_clk,
    input wire logic i_we,
    input wire logic [8:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);

    logic [7:0] mem [0:511];

    // Contents survive reset on purpose
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        o_rdata <= mem[i_addr];
    end

endmodule : rrm_ram

// ===== logic/rrm_regmap.sv
// Register map, primary control and clock divider of the real-time clock
// Function
// - Unimplemented bits always read zero
// - Undefined bits survive later resets unchanged
// - Bit 7 selects external clock test
// - Bit 5 halts and clears divider chain above prescaler
// - Three fastest square waves run while halted
// - Bit 4 flags intermediate tamper level
// - Tamper interrupt holds until host clears
// - Bit 3 enables power-up override reception
// - Bit 2 selects 12 or 24 hours
// - Bit 1 enables once-per-minute interrupt
// - Bit 0 enables once-per-second interrupt
// - Pointer increments, wraps after 0x1b
// - Time counters frozen during time access
// - Tamper event captures current time
// - Time values kept in BCD
`timescale 1ns/1ps
`include "rrm_consts.svh"
module rrm_regmap (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire rrm_pkg::rrm_req_s i_req,
    input wire logic i_xfer_active,
    output logic [7:0] o_rdata,
    output logic o_ext_sel,
    input wire logic [7:0] i_ext_rdata,
    input wire logic i_xtal_tick,
    input wire logic i_test_tick,
    input wire logic i_tamper_mid,
    input wire logic i_minute_carry,
    input wire rrm_pkg::rrm_time_s i_time,
    output rrm_pkg::rrm_ctl1_s o_ctl1,
    output logic o_freeze,
    output logic o_sec_tick,
    output logic o_sec_irq,
    output logic o_min_irq,
    output logic o_tamper_irq,
    output logic o_sqw_o,
    output logic o_sqw_oe,
    output logic [7:0] o_wd_ctl,
    output logic [7:0] o_wd_val,
    output logic [7:0] o_aging
);

    logic rst_s1_q;
    logic rst_n_q;
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    function automatic logic [7:0] mask_in(input logic [7:0] v,
                                           input logic [7:0] m);
        mask_in = v & m;
    endfunction : mask_in

    logic [4:0] ptr_q;
    logic [4:0] ptr_d;
    logic [7:0] ctl1_q;
    logic [7:0] ctl1_d;
    logic day_alm_en_q;
    logic [6:0] day_alm_lo_q;
    logic wday_alm_en_q;
    logic [6:0] wday_alm_lo_q;
    logic [7:0] sqw_ctl_q;
    logic [7:0] wd_ctl_q;
    logic [7:0] wd_val_q;
    logic [1:0] ts_mode_q;
    logic [5:0] ts_low_q;
    logic [7:0] aging_q;
    logic [8:0] ram_ptr_q;
    logic [8:0] ram_ptr_d;
    logic [7:0] rdata_q;
    logic [7:0] rd_mux;
    logic [7:0] ram_rdata;
    rrm_pkg::rrm_time_s cap_q;
    logic tamper_q;
    logic tamper_flag_q;
    logic [`RRM_DIV_BITS-1:0] div_q;
    logic [`RRM_DIV_BITS-1:0] div_d;
    logic sec_pend_q;
    logic sec_tick_q;
    logic min_irq_q;

    // Access decode
    wire acc = i_req.access;
    wire wr = acc & i_req.write;
    wire rd = acc & ~i_req.write;
    wire [4:0] cur = i_req.load ? i_req.addr : ptr_q;
    wire wr_ctl1 = wr && cur == `RRM_OFS_CTL1;
    wire wr_day = wr && cur == `RRM_OFS_DAY_ALM;
    wire wr_wday = wr && cur == `RRM_OFS_WDAY_ALM;
    wire wr_sqw = wr && cur == `RRM_OFS_SQW_CTL;
    wire wr_wdc = wr && cur == `RRM_OFS_WD_CTL;
    wire wr_wdv = wr && cur == `RRM_OFS_WD_VAL;
    wire wr_tsc = wr && cur == `RRM_OFS_TS_CTL;
    wire wr_age = wr && cur == `RRM_OFS_AGING;
    wire wr_rhi = wr && cur == `RRM_OFS_RAM_HI;
    wire wr_rlo = wr && cur == `RRM_OFS_RAM_LO;
    wire wr_ram = wr && cur == `RRM_OFS_RAM_WR;
    wire rd_ram = rd && cur == `RRM_OFS_RAM_RD;
    wire on_ram_port = cur == `RRM_OFS_RAM_WR || cur == `RRM_OFS_RAM_RD;
    wire in_ext = cur != `RRM_OFS_CTL1 && cur <= `RRM_OFS_EXT_LAST;
    wire in_time = cur >= `RRM_OFS_TIME_FIRST && cur <= `RRM_OFS_TIME_LAST;

    assign o_ext_sel = acc & in_ext;

    // Enable bits reset, value fields keep contents
    wire [7:0] day_alm_q = {day_alm_en_q, day_alm_lo_q};
    wire [7:0] wday_alm_q = {wday_alm_en_q, wday_alm_lo_q};
    wire [7:0] ts_ctl_q = {ts_mode_q, ts_low_q};
    wire [7:0] day_alm_w = mask_in(i_req.wdata, `RRM_MSK_DAY_ALM);
    wire [7:0] wday_alm_w = mask_in(i_req.wdata, `RRM_MSK_WDAY_ALM);
    wire [7:0] ts_low_w = mask_in(i_req.wdata, `RRM_MSK_TS_CTL_KEEP);

    // pointer auto-increment
    // RAM ports hold the pointer so bursts stream through memory
    always_comb begin
        ptr_d = ptr_q;
        if (i_req.load) begin
            ptr_d = i_req.addr;
        end
        if (acc) begin
            if (on_ram_port) begin
                ptr_d = cur;
            end else if (cur >= `RRM_OFS_WRAP) begin
                ptr_d = `RRM_OFS_ZERO;
            end else begin
                ptr_d = cur + 5'h01;
            end
        end
    end

    // RAM address steps after each data port access
    always_comb begin
        ram_ptr_d = ram_ptr_q;
        if (wr_rhi) begin
            ram_ptr_d = {i_req.wdata[0], ram_ptr_q[7:0]};
        end else if (wr_rlo) begin
            ram_ptr_d = {ram_ptr_q[8], i_req.wdata};
        end else if (wr_ram || rd_ram) begin
            ram_ptr_d = ram_ptr_q + 9'h001;
        end
    end

    // Tamper level is synchronous; event is its rising edge
    wire tamper_evt = i_tamper_mid & ~tamper_q;

    // flag only cleared by a written zero
    always_comb begin
        ctl1_d = ctl1_q;
        if (wr_ctl1) begin
            ctl1_d = mask_in(i_req.wdata, `RRM_MSK_CTL1);
            ctl1_d[`RRM_C1_TAMPER] = ctl1_q[`RRM_C1_TAMPER] &
                                     i_req.wdata[`RRM_C1_TAMPER];
        end
        // set on intermediate level, wins over clear
        if (tamper_evt) begin
            ctl1_d[`RRM_C1_TAMPER] = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ptr_q <= `RRM_OFS_ZERO;
            ctl1_q <= `RRM_RST_CTL1;
            tamper_q <= 1'b0;
            ram_ptr_q <= `RRM_RST_RAM_PTR;
        end else begin
            ptr_q <= ptr_d;
            ctl1_q <= ctl1_d;
            tamper_q <= i_tamper_mid;
            ram_ptr_q <= ram_ptr_d;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            day_alm_en_q <= `RRM_RST_ALM_EN;
            wday_alm_en_q <= `RRM_RST_ALM_EN;
            sqw_ctl_q <= `RRM_RST_SQW_CTL;
            wd_ctl_q <= `RRM_RST_WD_CTL;
            ts_mode_q <= `RRM_RST_TS_MODE;
            aging_q <= `RRM_RST_AGING;
        end else begin
            if (wr_day) begin
                day_alm_en_q <= i_req.wdata[`RRM_ALM_EN_BIT];
            end
            if (wr_wday) begin
                wday_alm_en_q <= i_req.wdata[`RRM_ALM_EN_BIT];
            end
            if (wr_sqw) begin
                sqw_ctl_q <= mask_in(i_req.wdata, `RRM_MSK_SQW_CTL);
            end
            if (wr_wdc) begin
                wd_ctl_q <= mask_in(i_req.wdata, `RRM_MSK_WD_CTL);
            end
            if (wr_tsc) begin
                ts_mode_q <= i_req.wdata[7:6];
            end
            if (wr_age) begin
                aging_q <= mask_in(i_req.wdata, `RRM_MSK_AGING);
            end
        end
    end

    // undefined fields keep contents across reset
    always_ff @(posedge i_clk) begin
        if (wr_day) begin
            day_alm_lo_q <= day_alm_w[6:0];
        end
        if (wr_wday) begin
            wday_alm_lo_q <= wday_alm_w[6:0];
        end
        if (wr_wdv) begin
            wd_val_q <= i_req.wdata;
        end
        if (wr_tsc) begin
            ts_low_q <= ts_low_w[5:0];
        end
        // capture on tamper unless timestamps are off
        // BCD fields stored with unused bits cleared
        if (tamper_evt && !ts_ctl_q[`RRM_TS_OFF_BIT]) begin
            cap_q.sec <= mask_in(i_time.sec, `RRM_MSK_SEC);
            cap_q.min <= mask_in(i_time.min, `RRM_MSK_SEC);
            cap_q.hour <= mask_in(i_time.hour, `RRM_MSK_HOUR);
            cap_q.day <= mask_in(i_time.day, `RRM_MSK_HOUR);
            cap_q.mon <= mask_in(i_time.mon, `RRM_MSK_MON);
            cap_q.year <= mask_in(i_time.year, `RRM_MSK_YEAR);
        end
    end

    rrm_ram u_ram (
        .i_clk(i_clk),
        .i_we(wr_ram),
        .i_addr(ram_ptr_q),
        .i_wdata(i_req.wdata),
        .o_rdata(ram_rdata)
    );

    // unmapped and unimplemented bits read zero
    always_comb begin
        rd_mux = 8'h00;
        if (cur == `RRM_OFS_CTL1) begin
            rd_mux = mask_in(ctl1_q, `RRM_MSK_CTL1);
        end else if (in_ext) begin
            rd_mux = i_ext_rdata;
        end else if (cur == `RRM_OFS_DAY_ALM) begin
            rd_mux = mask_in(day_alm_q, `RRM_MSK_DAY_ALM);
        end else if (cur == `RRM_OFS_WDAY_ALM) begin
            rd_mux = mask_in(wday_alm_q, `RRM_MSK_WDAY_ALM);
        end else if (cur == `RRM_OFS_SQW_CTL) begin
            rd_mux = sqw_ctl_q;
        end else if (cur == `RRM_OFS_WD_CTL) begin
            rd_mux = wd_ctl_q;
        end else if (cur == `RRM_OFS_WD_VAL) begin
            rd_mux = wd_val_q;
        end else if (cur == `RRM_OFS_TS_CTL) begin
            rd_mux = mask_in(ts_ctl_q, `RRM_MSK_TS_CTL);
        end else if (cur == `RRM_OFS_CAP_SEC) begin
            rd_mux = cap_q.sec;
        end else if (cur == `RRM_OFS_CAP_MIN) begin
            rd_mux = cap_q.min;
        end else if (cur == `RRM_OFS_CAP_HOUR) begin
            rd_mux = cap_q.hour;
        end else if (cur == `RRM_OFS_CAP_DAY) begin
            rd_mux = cap_q.day;
        end else if (cur == `RRM_OFS_CAP_MON) begin
            rd_mux = cap_q.mon;
        end else if (cur == `RRM_OFS_CAP_YEAR) begin
            rd_mux = cap_q.year;
        end else if (cur == `RRM_OFS_AGING) begin
            rd_mux = aging_q;
        end else if (cur == `RRM_OFS_RAM_HI) begin
            rd_mux = mask_in({7'h00, ram_ptr_q[8]}, `RRM_MSK_RAM_HI);
        end else if (cur == `RRM_OFS_RAM_LO) begin
            rd_mux = ram_ptr_q[7:0];
        end else if (cur == `RRM_OFS_RAM_RD) begin
            rd_mux = ram_rdata;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= 8'h00;
        end else if (rd) begin
            rdata_q <= rd_mux;
        end
    end

    // test mode swaps the divider source
    wire div_tick = ctl1_q[`RRM_C1_EXTERNAL_CLOCK_CHECK_MODE] ? i_test_tick : i_xtal_tick;
    wire stop = ctl1_q[`RRM_C1_STOP];

    // halt clears chain above the prescaler
    // prescaler keeps running for fast square waves
    always_comb begin
        div_d = div_q;
        if (div_tick) begin
            div_d = div_q + 16'h0001;
        end
        if (stop) begin
            div_d[`RRM_DIV_BITS-1:`RRM_DIV_PRE_BITS] = '0;
        end
    end

    // Carry out of the chain is the one-second event
    wire sec_carry = div_tick && !stop && div_q == `RRM_DIV_TOP;

    // hold time counters during time register access
    assign o_freeze = i_xfer_active & in_time;

    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            div_q <= '0;
            sec_pend_q <= 1'b0;
            sec_tick_q <= 1'b0;
            min_irq_q <= 1'b0;
        end else begin
            div_q <= div_d;
            // a second seen while frozen is delivered late
            sec_pend_q <= (sec_pend_q | sec_carry) & o_freeze;
            sec_tick_q <= (sec_pend_q | sec_carry) & ~o_freeze;
            min_irq_q <= i_minute_carry & ctl1_q[`RRM_C1_MIN_IE];
        end
    end

    // Chosen wave; slow rates come from the masked chain
    wire [2:0] cof = sqw_ctl_q[2:0];
    wire sqw_on = cof != `RRM_SQW_OFF;
    wire sqw_lvl = cof == `RRM_SQW_1HZ ? div_q[`RRM_DIV_BITS-1] :
                   div_q[cof];
    // Open drain: drive low only
    assign o_sqw_o = 1'b0;
    assign o_sqw_oe = sqw_on & ~sqw_lvl;

    assign o_sec_tick = sec_tick_q;
    assign o_sec_irq = sec_tick_q & ctl1_q[`RRM_C1_SEC_IE];
    assign o_min_irq = min_irq_q;
    assign o_tamper_irq = ctl1_q[`RRM_C1_TAMPER];
    assign o_rdata = rdata_q;
    assign o_wd_ctl = wd_ctl_q;
    assign o_wd_val = wd_val_q;
    assign o_aging = aging_q;

    assign o_ctl1.external_clock_check_mode = ctl1_q[`RRM_C1_EXTERNAL_CLOCK_CHECK_MODE];
    assign o_ctl1.stop = stop;
    assign o_ctl1.tamper_flag = ctl1_q[`RRM_C1_TAMPER];
    assign o_ctl1.powerup_reset_override_enable_en = ctl1_q[`RRM_C1_POWERUP_RESET_OVERRIDE_ENABLE];
    assign o_ctl1.hour12 = ctl1_q[`RRM_C1_HOUR12];
    assign o_ctl1.min_ie = ctl1_q[`RRM_C1_MIN_IE];
    assign o_ctl1.sec_ie = ctl1_q[`RRM_C1_SEC_IE];

endmodule : rrm_regmap

// ===== bench/rrm_regmap_properties.sv
// Concurrent checks on the register map ports
`timescale 1ns/1ps
module rrm_regmap_properties (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire rrm_pkg::rrm_req_s i_req,
    input wire logic i_xfer_active,
    input wire logic i_tamper_mid,
    input wire logic i_minute_carry,
    input wire logic [7:0] o_rdata,
    input wire logic o_ext_sel,
    input wire rrm_pkg::rrm_ctl1_s o_ctl1,
    input wire logic o_freeze,
    input wire logic o_sec_tick,
    input wire logic o_sec_irq,
    input wire logic o_min_irq,
    input wire logic o_tamper_irq
);
    logic [1:0] live_q;
    logic [7:0] wd_q;
    logic live;
    logic wr_c1;
    logic min_cause;
    logic stop;
    assign live = (live_q == 2'h3);
    assign wr_c1 = i_req.access & i_req.load & i_req.write
        & (i_req.addr == 5'h00);
    assign min_cause = i_minute_carry & o_ctl1.min_ie;
    assign stop = o_ctl1.stop;

    // Internal reset copy lags the pin by two edges
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            live_q <= 2'h0;
        end else if (!live) begin
            live_q <= live_q + 2'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        wd_q <= i_req.wdata;
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    a_tamper_sets: assert property (
        live && $rose(i_tamper_mid) |=> o_tamper_irq)
        else $error("tamper flag missed");
    a_tamper_holds: assert property (
        o_tamper_irq && !i_req.access |=> o_tamper_irq)
        else $error("tamper irq dropped without access");
    a_irq_is_flag: assert property (
        o_tamper_irq == o_ctl1.tamper_flag)
        else $error("tamper irq differs from flag");
    a_sec_gate: assert property (
        o_sec_irq == (o_sec_tick && o_ctl1.sec_ie))
        else $error("second irq gating wrong");
    a_min_delay: assert property (
        live |=> o_min_irq == $past(min_cause))
        else $error("minute irq wrong");
    a_stop_quiet: assert property (
        stop && $past(stop) && $past(stop, 2) && !$past(o_freeze)
        && !$past(o_freeze, 2) |-> !o_sec_tick)
        else $error("second tick while halted");
    a_freeze_idle: assert property (
        !i_xfer_active |-> !o_freeze)
        else $error("freeze without transfer");
    a_freeze_time: assert property (
        live && i_xfer_active && i_req.load
        && i_req.addr inside {[5'h03:5'h09]} |-> o_freeze)
        else $error("time access not frozen");
    a_unmapped_zero: assert property (
        live && i_req.access && i_req.load && !i_req.write
        && i_req.addr >= 5'h1e |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_ctl_write: assert property (
        live && wr_c1 |=> {o_ctl1.external_clock_check_mode, stop, o_ctl1.powerup_reset_override_enable_en,
        o_ctl1.hour12, o_ctl1.min_ie, o_ctl1.sec_ie}
        == {wd_q[7], wd_q[5], wd_q[3:0]})
        else $error("control bits not written");

    a_ext_sel_decode: assert property (
        i_req.access && i_req.load |-> o_ext_sel
        == (i_req.addr inside {[5'h01:5'h0c]}))
        else $error("forwarded range decode wrong");

    c_tamper: cover property (o_tamper_irq ##1 !o_tamper_irq);
    c_sec: cover property (o_sec_irq);
    c_min: cover property (o_min_irq);
    c_freeze: cover property (o_freeze);
endmodule : rrm_regmap_properties

// ===== bench/rrm_host_model.sv
// Host side model issuing byte accesses to the register map
`timescale 1ns/1ps
module rrm_host_model (
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    output rrm_pkg::rrm_req_s o_req,
    output logic o_xfer_active
);
    initial begin
        o_req = '0;
        o_xfer_active = 1'b0;
    end

    // One byte access, taken at a single rising edge
    task automatic acc(input logic ld, input logic [4:0] a,
                       input logic wr, input logic [7:0] wd,
                       output logic [7:0] rd);
        @(negedge i_clk);
        o_xfer_active = 1'b1;
        o_req = '{ld, a, 1'b1, wr, wd};
        @(negedge i_clk);
        // Released lines must not look like the last request
        o_req = '{1'b0, ~a, 1'b0, wr, ~wd};
        o_xfer_active = 1'b0;
        rd = i_rdata;
        repeat ($urandom_range(2)) @(negedge i_clk);
    endtask : acc

    // clear flag, write back the rest
    task automatic clear_tamper();
        logic [7:0] c;
        acc(1'b1, 5'h00, 1'b0, 8'h00, c);
        acc(1'b1, 5'h00, 1'b1, c & 8'haf, c);
    endtask : clear_tamper
endmodule : rrm_host_model

// ===== bench/tb_top.sv
// Self-checking bench for the register map and control register
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %0t got %h expected %h", $time, a, e); end end
module tb_top;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    rrm_pkg::rrm_req_s i_req;
    rrm_pkg::rrm_time_s i_time = '0;
    rrm_pkg::rrm_ctl1_s o_ctl1;
    logic i_xfer_active, o_ext_sel, o_freeze, o_sec_tick, o_sec_irq;
    logic o_min_irq, o_tamper_irq, o_sqw_oe, o_sqw_o;
    logic i_xtal_tick = 1'b0;
    logic i_test_tick = 1'b0;
    logic i_tamper_mid = 1'b0;
    logic i_minute_carry = 1'b0;
    logic [7:0] i_ext_rdata = 8'h00;
    logic [7:0] o_rdata, r, v, o_wd_ctl, o_wd_val, o_aging;
    logic [7:0] pw [6];
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    int n;
    // Entries: address, read mask, expected value
    localparam logic [23:0] RT [9] = '{24'h00ff00, 24'h0fff00, 24'h10ff03,
        24'h19ff08, 24'h1aff00, 24'h1bff00, 24'h0d8080, 24'h0e8080,
        24'h1eff00};
    localparam logic [15:0] WT [8] = '{16'h0dbf, 16'h0e87, 16'h0fc7,
        16'h10e3, 16'h11ff, 16'h12df, 16'h190f, 16'h1a01};
    localparam logic [7:0] CM [6] = '{8'h7f, 8'h7f, 8'h3f, 8'h3f, 8'h1f,
        8'hff};
    // Entries: control byte, square wave select
    localparam logic [15:0] DT [5] = '{16'h0003, 16'h2000, 16'h2002,
        16'h2003, 16'h8000};

    rrm_regmap u_dut (.i_clk, .i_arst_n, .i_req, .i_xfer_active, .o_rdata,
        .o_ext_sel, .i_ext_rdata, .i_xtal_tick, .i_test_tick, .i_tamper_mid,
        .i_minute_carry, .i_time, .o_ctl1, .o_freeze, .o_sec_tick,
        .o_sec_irq, .o_min_irq, .o_tamper_irq, .o_sqw_o, .o_sqw_oe,
        .o_wd_ctl, .o_wd_val, .o_aging);
    rrm_host_model u_host (.i_clk, .i_rdata(o_rdata), .o_req(i_req),
        .o_xfer_active(i_xfer_active));

    always #20 i_clk = ~i_clk;

    function automatic rrm_pkg::rrm_ctl1_s ctl_of(input logic [7:0] w);
        return '{w[7], w[5], 1'b0, w[3], w[2], w[1], w[0]};
    endfunction : ctl_of

    // Halting keeps only the three fastest selects alive
    function automatic logic sqw_runs(input logic [15:0] d);
        return !d[13] || (d[2:0] <= 3'h2);
    endfunction : sqw_runs

    task automatic do_reset();
        @(negedge i_clk) i_arst_n = 1'b0;
        repeat (4) @(posedge i_clk);
        @(negedge i_clk) i_arst_n = 1'b1;
        repeat (3) @(posedge i_clk);
    endtask : do_reset

    task automatic stop_test();
        if (n_mismatch == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    // Whole run needs about 66300 cycles
    always @(posedge i_clk) begin
        cyc++;
        if (cyc > 90000) begin
            n_mismatch++;
            stop_test();
        end
    end

    initial begin
        void'($urandom(61324));
        do_reset();
        for (int k = 0; k < 9; k++) begin
            u_host.acc(1'b1, RT[k][20:16], 1'b0, 8'h00, r);
            `CHK(r & RT[k][15:8], RT[k][7:0])
        end
        for (int p = 0; p < 3; p++) begin
            for (int k = 0; k < 8; k++) begin
                v = (p == 0) ? 8'($urandom) : {8{p == 1}};
                u_host.acc(1'b1, WT[k][12:8], 1'b1, v, r);
                u_host.acc(1'b1, WT[k][12:8], 1'b0, 8'h00, r);
                `CHK(r, v & WT[k][7:0])
            end
        end
        v = 8'($urandom);
        u_host.acc(1'b1, 5'h11, 1'b1, v, r);
        do_reset();
        u_host.acc(1'b1, 5'h11, 1'b0, 8'h00, r);
        `CHK(r, v)
        `CHK(o_wd_val, v)
        `CHK(o_wd_ctl, 8'h03)
        repeat (8) begin
            // bit six always written as zero
            v = 8'($urandom) & 8'hbf;
            u_host.acc(1'b1, 5'h00, 1'b1, v, r);
            u_host.acc(1'b1, 5'h00, 1'b0, 8'h00, r);
            `CHK(r, v & 8'haf)
            `CHK(o_ctl1, ctl_of(v))
        end
        u_host.acc(1'b1, 5'h00, 1'b1, 8'h00, r);
        i_ext_rdata = 8'($urandom);
        pw = '{8'($urandom) & 8'h0f, 8'h01, 8'($urandom), 8'h00,
            i_ext_rdata, i_ext_rdata};
        for (int k = 0; k < 3; k++) begin
            u_host.acc(k == 0, 5'h19, 1'b1, pw[k], r);
        end
        for (int k = 0; k < 6; k++) begin
            u_host.acc(k == 0, 5'h19, 1'b0, 8'h00, r);
            `CHK(r, pw[k])
        end
        `CHK(o_aging, pw[0])
        u_host.acc(1'b1, 5'h05, 1'b0, 8'h00, r);
        `CHK(r, i_ext_rdata)
        i_time = 48'({$urandom, $urandom});
        @(negedge i_clk) i_tamper_mid = 1'b1;
        @(negedge i_clk) i_tamper_mid = 1'b0;
        `CHK(o_tamper_irq, 1'b1)
        for (int k = 0; k < 6; k++) begin
            u_host.acc(k == 0, 5'h13, 1'b0, 8'h00, r);
            `CHK(r, i_time[47 - 8 * k -: 8] & CM[k])
        end
        `CHK(o_tamper_irq, 1'b1)
        u_host.clear_tamper();
        `CHK(o_tamper_irq, 1'b0)
        for (int k = 0; k < 2; k++) begin
            u_host.acc(1'b1, 5'h00, 1'b1, 8'(2 * k), r);
            @(negedge i_clk) i_minute_carry = 1'b1;
            @(negedge i_clk) i_minute_carry = 1'b0;
            `CHK(o_min_irq, k[0])
        end
        for (int k = 0; k < 5; k++) begin
            u_host.acc(1'b1, 5'h00, 1'b1, DT[k][15:8], r);
            u_host.acc(1'b1, 5'h0f, 1'b1, DT[k][7:0], r);
            {i_test_tick, i_xtal_tick} = DT[k][15] ? 2'b10 : 2'b01;
            n = 0;
            repeat (64) begin
                v[0] = o_sqw_oe;
                @(negedge i_clk);
                n += int'(o_sqw_oe !== v[0]);
            end
            `CHK(n > 3, sqw_runs(DT[k]))
            `CHK(o_sqw_o, 1'b0)
        end
        u_host.acc(1'b1, 5'h00, 1'b1, 8'h21, r);
        u_host.acc(1'b1, 5'h00, 1'b1, 8'h01, r);
        {i_test_tick, i_xtal_tick} = 2'b01;
        n = 0;
        repeat (65600) begin
            @(negedge i_clk);
            n += int'(o_sec_irq === 1'b1);
        end
        `CHK(n, 1)
        stop_test();
    end
endmodule : tb_top

bind rrm_regmap rrm_regmap_properties u_props (.i_clk, .i_arst_n, .i_req,
    .i_xfer_active, .i_tamper_mid, .i_minute_carry, .o_rdata, .o_ext_sel,
    .o_ctl1,
    .o_freeze, .o_sec_tick, .o_sec_irq, .o_min_irq, .o_tamper_irq);
